// File: dv/pcrc_assertions.sv
// port checker for the power, clock and reset control block
`timescale 1ns/1ps
`default_nettype none
module pcrc_checker #(
	parameter int RESET_CYCLES = 4
) (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       hreadyout,
	input wire logic       sample_valid,
	input wire logic       buffer_write,
	input wire logic       otp_read,
	input wire logic       aux_master_enable,
	input wire logic       aux_passthrough,
	input wire logic       aux_reset,
	input wire logic       gyro_analog_reset,
	input wire logic       gyro_digital_reset,
	input wire logic       core_active,
	input wire logic       x_axis_standby,
	input wire logic       y_axis_standby,
	input wire logic       z_axis_standby,
	input wire logic [2:0] clock_source,
	input wire logic       pll_enable,
	input wire logic       clock_stop,
	input wire logic       clock_state_reset,
	input wire logic       device_soft_reset
);
	logic [7:0] aux_len;

	// length of the current aux reset pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			aux_len <= 8'h00;
		else if (aux_reset)
			aux_len <= aux_len + 8'h01;
		else
			aux_len <= 8'h00;
	end

	a_write_needs_sample: assert property (@(posedge clk) disable iff (!rst_b)
		buffer_write |-> $past(sample_valid)) else $error("buffer write without sample");
	a_aux_pass_inverse: assert property (@(posedge clk) disable iff (!rst_b)
		aux_passthrough != aux_master_enable) else $error("aux passthrough not inverse");
	a_gyro_reset_pair: assert property (@(posedge clk) disable iff (!rst_b)
		gyro_analog_reset == gyro_digital_reset) else $error("gyro resets differ");
	a_aux_pulse_len: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(aux_reset) && !device_soft_reset && !$past(device_soft_reset)
		|-> aux_len == RESET_CYCLES) else $error("aux reset pulse length wrong");
	a_sleep_standby: assert property (@(posedge clk) disable iff (!rst_b)
		!core_active |-> x_axis_standby && y_axis_standby && z_axis_standby)
		else $error("axis active while asleep");
	a_seq_sets_sleep: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(otp_read) && !device_soft_reset |-> ##[0:2] !core_active)
		else $error("sleep not set after otp read");
	a_stop_drops_pll: assert property (@(posedge clk) disable iff (!rst_b)
		clock_stop && $past(clock_stop) |-> !pll_enable && clock_state_reset)
		else $error("stopped clock keeps pll");
	a_soft_reset_clears: assert property (@(posedge clk) disable iff (!rst_b)
		device_soft_reset && $past(device_soft_reset, 3)
		|-> clock_source == 3'h0 && !aux_master_enable) else $error("soft reset left state");
	a_read_wait_one: assert property (@(posedge clk) disable iff (!rst_b)
		!hreadyout |=> hreadyout) else $error("read wait longer than one cycle");
endmodule : pcrc_checker

bind pcrc_top pcrc_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.clk, .rst_b, .hreadyout,
	.sample_valid, .buffer_write, .otp_read, .aux_master_enable, .aux_passthrough, .aux_reset,
	.gyro_analog_reset, .gyro_digital_reset, .core_active, .x_axis_standby, .y_axis_standby,
	.z_axis_standby, .clock_source, .pll_enable, .clock_stop, .clock_state_reset,
	.device_soft_reset);
`default_nettype wire

// File: dv/tb_power_clock_reset_control.sv
// self-checking bench for the power, clock and reset control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, a, e); end end
// bounded wait, sampled mid-cycle to stay clear of the edge
`define WAITON(c) for (int n = 0; n <= 60; n++) begin @(negedge clk); if (c) break; \
	if (n == 60) begin fails++; tally_and_finish(); end end @(posedge clk);
module tb_power_clock_reset_control;
	import pcrc_pkg::*;
	typedef struct packed {
		logic [7:0] pm;
		logic [2:0] src;
		logic       pll;
		logic       stop;
		logic [2:0] stby;
	} pcrc_row_t;
	localparam logic [31:0] UC = {22'h0, UC_INDEX, 2'h0};
	localparam logic [31:0] PM = {22'h0, PM_INDEX, 2'h0};
	logic clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic pump_ready = 1'h0, otp_done = 1'h0, sample_valid = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [CLK_W-1:0] clock_source;
	logic hreadyout, hresp, pump_enable, otp_read, buffer_write, buffer_flush, seen;
	logic aux_master_enable, aux_passthrough, aux_reset, gyro_analog_reset, gyro_digital_reset;
	logic core_active, x_axis_standby, y_axis_standby, z_axis_standby;
	logic pll_enable, clock_stop, clock_state_reset, device_soft_reset;
	int fails = 0;
	int samples_checked = 0;
	// code 6 is reserved, so the source stays at the previous one
	pcrc_row_t rows [9] = '{
		'{8'h00, 3'h0, 1'h0, 1'h0, 3'h0}, '{8'h21, 3'h1, 1'h1, 1'h0, 3'h4},
		'{8'h12, 3'h2, 1'h1, 1'h0, 3'h2}, '{8'h0B, 3'h3, 1'h1, 1'h0, 3'h1},
		'{8'h04, 3'h4, 1'h1, 1'h0, 3'h0}, '{8'h05, 3'h5, 1'h1, 1'h0, 3'h0},
		'{8'h06, 3'h5, 1'h1, 1'h0, 3'h0}, '{8'h07, 3'h7, 1'h0, 1'h1, 3'h0},
		'{8'h38, 3'h0, 1'h0, 1'h0, 3'h7}};

	pcrc_top #(.RESET_CYCLES(4)) DUT (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pump_ready, .otp_done,
		.pump_enable, .otp_read, .sample_valid, .buffer_write, .buffer_flush,
		.aux_master_enable, .aux_passthrough, .aux_reset, .gyro_analog_reset,
		.gyro_digital_reset, .core_active, .x_axis_standby, .y_axis_standby, .z_axis_standby,
		.clock_source, .pll_enable, .clock_stop, .clock_state_reset, .device_soft_reset);

	always #5 clk = ~clk;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// hready is stable from mid-cycle up to the edge that samples it
	task automatic bus_wait;
		int n;
		logic r;
		n = 0;
		r = 1'h0;
		while (!r) begin
			@(negedge clk);
			r = hreadyout;
			rd = hrdata;
			@(posedge clk);
			n++;
			if (n > 20) begin
				fails++;
				tally_and_finish();
			end
		end
	endtask : bus_wait

	task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		bus_wait();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		bus_wait();
	endtask : bus

	task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
		bus(a, 1'h0, 8'h00);
		`CHK(rd, {24'h0, e})
	endtask : rd_chk

	task automatic sample(output logic s);
		sample_valid <= 1'h1;
		@(posedge clk);
		sample_valid <= 1'h0;
		#1 s = buffer_write;
		@(posedge clk);
	endtask : sample

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		rd_chk(PM, 8'h00);
		rd_chk(UC, 8'h00);
		@(negedge clk);
		`CHK({clock_source, core_active, pump_enable, hresp}, 6'h06)
		@(posedge clk);
		pump_ready <= 1'h1;
		`WAITON(otp_read)
		otp_done <= 1'h1;
		`WAITON(!core_active)
		rd_chk(PM, 8'h40);
		rd_chk(32'h100, 8'h00);
		for (int i = 0; i < 9; i++) begin
			bus(PM, 1'h1, rows[i].pm);
			rd_chk(PM, rows[i].pm);
			@(negedge clk);
			`CHK(clock_source, rows[i].src)
			`CHK({pll_enable, clock_stop, clock_state_reset}, {rows[i].pll, rows[i].stop, rows[i].stop})
			`CHK({x_axis_standby, y_axis_standby, z_axis_standby}, rows[i].stby)
			`CHK(core_active, 1'h1)
			@(posedge clk);
		end
		bus(UC, 1'h1, 8'h01);
		`WAITON(gyro_analog_reset && gyro_digital_reset)
		`WAITON(!gyro_analog_reset)
		rd_chk(UC, 8'h00);
		bus(UC, 1'h1, 8'h20);
		// enable lands at the write edge, the output flop one cycle later
		repeat (2) @(negedge clk);
		`CHK({aux_master_enable, aux_passthrough}, 2'h2)
		@(posedge clk);
		bus(UC, 1'h1, 8'h00);
		bus(UC, 1'h1, 8'h08);
		`WAITON(aux_reset)
		`WAITON(!aux_reset)
		rd_chk(UC, 8'h00);
		bus(UC, 1'h1, 8'h42);
		`WAITON(buffer_flush)
		`WAITON(!buffer_flush)
		rd_chk(UC, 8'h40);
		sample(seen);
		`CHK(seen, 1'h1)
		bus(PM, 1'h1, 8'h40);
		sample(seen);
		`CHK(seen, 1'h0)
		bus(PM, 1'h1, 8'h00);
		sample(seen);
		`CHK(seen, 1'h1)
		bus(UC, 1'h1, 8'h02);
		sample(seen);
		`CHK(seen, 1'h0)
		// after the flush only the cleared enable can block the sample
		`WAITON(!buffer_flush)
		sample(seen);
		`CHK(seen, 1'h0)
		bus(UC, 1'h1, 8'h20);
		bus(PM, 1'h1, 8'h85);
		`WAITON(device_soft_reset)
		`WAITON(!device_soft_reset)
		`WAITON(!core_active)
		rd_chk(PM, 8'h40);
		rd_chk(UC, 8'h00);
		@(negedge clk);
		`CHK(aux_master_enable, 1'h0)
		tally_and_finish();
	end
endmodule : tb_power_clock_reset_control
`default_nettype wire

// File: shared/pcrc_pkg.sv
// constants for the power, clock and reset control block
package pcrc_pkg;
	// register word indices; byte address is four times the index
	localparam logic [7:0] UC_INDEX = 8'h3D;
	localparam logic [7:0] PM_INDEX = 8'h3E;
	localparam logic [7:0] ST_INDEX = 8'h3F;

	// user_control fields
	localparam int UC_CAPTURE_EN_BIT = 6;
	localparam int UC_AUX_EN_BIT     = 5;
	localparam int UC_AUX_RST_BIT    = 3;
	localparam int UC_BUF_CLR_BIT    = 1;
	localparam int UC_GYRO_RST_BIT   = 0;
	localparam logic [7:0] UC_RESET  = 8'h00;

	// power_management fields
	localparam int PM_SOFT_RST_BIT  = 7;
	localparam int PM_SLEEP_BIT     = 6;
	localparam int PM_STBY_X_BIT    = 5;
	localparam int PM_STBY_Y_BIT    = 4;
	localparam int PM_STBY_Z_BIT    = 3;
	localparam int PM_CLK_LSB       = 0;
	localparam int CLK_W            = 3;
	localparam logic [7:0] PM_RESET = 8'h00;

	// status fields
	localparam int ST_SEQ_DONE_BIT = 0;
	localparam int ST_CLK_STOP_BIT = 1;
	localparam int ST_RESERVED_BIT = 2;
	localparam int ST_SRC_LSB      = 3;
	localparam int ST_ASLEEP_BIT   = 6;

	// timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int FUNC_RESET_NS     = 40;
	localparam int FUNC_RESET_CYCLES =
		(FUNC_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [CLK_W-1:0] {
		CLK_INT_OSC  = 3'h0,
		CLK_PLL_X    = 3'h1,
		CLK_PLL_Y    = 3'h2,
		CLK_PLL_Z    = 3'h3,
		CLK_PLL_32K  = 3'h4,
		CLK_PLL_19M  = 3'h5,
		CLK_RESERVED = 3'h6,
		CLK_STOP     = 3'h7
	} pcrc_clk_t;

	typedef enum logic [2:0] {
		SEQ_PUMP = 3'b001,
		SEQ_OTP  = 3'b010,
		SEQ_RUN  = 3'b100
	} pcrc_seq_t;
endpackage : pcrc_pkg

// File: verilog/pcrc_reset_pulse.sv
// self-clearing function reset pulse of fixed length
`timescale 1ns/1ps
`default_nettype none
module pcrc_reset_pulse #(
	parameter int CYCLES = 4
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic clr,
	input  wire logic start,
	output logic      busy
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] count;

	// start wins over clear so a request is never dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (start) begin
			count <= LOAD;
		end else if (clr) begin
			count <= '0;
		end else if (count != '0) begin
			count <= count - CW'(1);
		end
	end

	assign busy = (count != '0);
endmodule : pcrc_reset_pulse
`default_nettype wire

// File: verilog/pcrc_top.sv
// power, clock-source and reset control with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module pcrc_top #(
	parameter int RESET_CYCLES = pcrc_pkg::FUNC_RESET_CYCLES
) (
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic [31:0]                     hrdata,
	input  wire logic                       pump_ready,
	input  wire logic                       otp_done,
	output logic                            pump_enable,
	output logic                            otp_read,
	input  wire logic                       sample_valid,
	output logic                            buffer_write,
	output logic                            buffer_flush,
	output logic                            aux_master_enable,
	output logic                            aux_passthrough,
	output logic                            aux_reset,
	output logic                            gyro_analog_reset,
	output logic                            gyro_digital_reset,
	output logic                            core_active,
	output logic                            x_axis_standby,
	output logic                            y_axis_standby,
	output logic                            z_axis_standby,
	output logic [pcrc_pkg::CLK_W-1:0]      clock_source,
	output logic                            pll_enable,
	output logic                            clock_stop,
	output logic                            clock_state_reset,
	output logic                            device_soft_reset
);
	import pcrc_pkg::*;

	// reset release synchroniser
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// bus state
	logic       take;
	logic       wr_pend;
	logic       rd_stage;
	logic [7:0] dp_idx;
	logic       wr_uc;
	logic       wr_pm;

	// register state
	logic                capture_en;
	logic                aux_en;
	logic                sleep;
	logic [2:0]          standby;
	logic [CLK_W-1:0]    clk_sel;
	logic [CLK_W-1:0]    eff_src;
	pcrc_seq_t           seq;
	pcrc_seq_t           next_seq;

	// self-clearing reset pulses
	logic soft_busy;
	logic buf_busy;
	logic aux_busy;
	logic gyro_busy;
	logic [7:0] uc_view;
	logic [7:0] pm_view;
	logic [7:0] st_view;

	assign take  = hsel & htrans[1] & hready;
	assign wr_uc = wr_pend & (dp_idx == UC_INDEX);
	assign wr_pm = wr_pend & (dp_idx == PM_INDEX);

	// address phase capture; reads get one wait state so that hrdata
	// comes from a flop and a read right after a write sees new data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend  <= 1'b0;
			rd_stage <= 1'b0;
			dp_idx   <= 8'h00;
		end else begin
			wr_pend  <= take & hwrite;
			rd_stage <= take & ~hwrite;
			if (take) begin
				dp_idx <= haddr[9:2];
			end
		end
	end

	assign hreadyout = ~rd_stage;
	assign hresp     = 1'b0;

	always_comb begin
		uc_view                    = 8'h00;
		uc_view[UC_CAPTURE_EN_BIT] = capture_en;
		uc_view[UC_AUX_EN_BIT]     = aux_en;
		uc_view[UC_AUX_RST_BIT]    = aux_busy;
		uc_view[UC_BUF_CLR_BIT]    = buf_busy;
		uc_view[UC_GYRO_RST_BIT]   = gyro_busy;
	end

	always_comb begin
		pm_view                                = 8'h00;
		pm_view[PM_SOFT_RST_BIT]               = soft_busy;
		pm_view[PM_SLEEP_BIT]                  = sleep;
		pm_view[PM_STBY_X_BIT]                 = standby[2];
		pm_view[PM_STBY_Y_BIT]                 = standby[1];
		pm_view[PM_STBY_Z_BIT]                 = standby[0];
		pm_view[PM_CLK_LSB +: CLK_W]           = clk_sel;
	end

	always_comb begin
		st_view                          = 8'h00;
		st_view[ST_SEQ_DONE_BIT]         = (seq == SEQ_RUN);
		st_view[ST_CLK_STOP_BIT]         = (clk_sel == CLK_STOP);
		st_view[ST_RESERVED_BIT]         = (clk_sel == CLK_RESERVED);
		st_view[ST_SRC_LSB +: CLK_W]     = eff_src;
		st_view[ST_ASLEEP_BIT]           = sleep;
	end

	// read data loaded in the wait cycle; unmapped words read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (rd_stage) begin
			case (dp_idx)
				UC_INDEX: hrdata <= {24'h000000, uc_view};
				PM_INDEX: hrdata <= {24'h000000, pm_view};
				ST_INDEX: hrdata <= {24'h000000, st_view};
				default:  hrdata <= 32'h00000000;
			endcase
		end
	end

	// soft reset itself is not cleared by its own pulse
	pcrc_reset_pulse #(
		.CYCLES (RESET_CYCLES)
	) u_soft (
		.clk   (clk),
		.rst_n (rst_n),
		.clr   (1'b0),
		.start (wr_pm & hwdata[PM_SOFT_RST_BIT]),
		.busy  (soft_busy)
	);

	pcrc_reset_pulse #(
		.CYCLES (RESET_CYCLES)
	) u_buf (
		.clk   (clk),
		.rst_n (rst_n),
		.clr   (soft_busy),
		.start (wr_uc & hwdata[UC_BUF_CLR_BIT]),
		.busy  (buf_busy)
	);

	pcrc_reset_pulse #(
		.CYCLES (RESET_CYCLES)
	) u_aux (
		.clk   (clk),
		.rst_n (rst_n),
		.clr   (soft_busy),
		.start (wr_uc & hwdata[UC_AUX_RST_BIT]),
		.busy  (aux_busy)
	);

	pcrc_reset_pulse #(
		.CYCLES (RESET_CYCLES)
	) u_gyro (
		.clk   (clk),
		.rst_n (rst_n),
		.clr   (soft_busy),
		.start (wr_uc & hwdata[UC_GYRO_RST_BIT]),
		.busy  (gyro_busy)
	);

	// user_control enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_en <= UC_RESET[UC_CAPTURE_EN_BIT];
			aux_en     <= UC_RESET[UC_AUX_EN_BIT];
		end else if (soft_busy) begin
			capture_en <= UC_RESET[UC_CAPTURE_EN_BIT];
			aux_en     <= UC_RESET[UC_AUX_EN_BIT];
		end else if (wr_uc) begin
			capture_en <= hwdata[UC_CAPTURE_EN_BIT];
			aux_en     <= hwdata[UC_AUX_EN_BIT];
		end
	end

	// power_management fields other than sleep
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			standby <= PM_RESET[PM_STBY_X_BIT:PM_STBY_Z_BIT];
			clk_sel <= PM_RESET[PM_CLK_LSB +: CLK_W];
		end else if (soft_busy) begin
			standby <= PM_RESET[PM_STBY_X_BIT:PM_STBY_Z_BIT];
			clk_sel <= PM_RESET[PM_CLK_LSB +: CLK_W];
		end else if (wr_pm) begin
			standby <= hwdata[PM_STBY_X_BIT:PM_STBY_Z_BIT];
			clk_sel <= hwdata[PM_CLK_LSB +: CLK_W];
		end
	end

	// power-up sequence: pumps, then OTP load, then forced sleep
	always_comb begin
		next_seq = seq;
		case (seq)
			SEQ_PUMP: begin
				if (pump_ready) begin
					next_seq = SEQ_OTP;
				end
			end
			SEQ_OTP: begin
				if (otp_done) begin
					next_seq = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				next_seq = SEQ_RUN;
			end
			default: begin
				next_seq = SEQ_PUMP;
			end
		endcase
	end

	// soft reset reruns the sequence like a power-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq <= SEQ_PUMP;
		end else if (soft_busy) begin
			seq <= SEQ_PUMP;
		end else begin
			seq <= next_seq;
		end
	end

	// the sequencer's set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep <= PM_RESET[PM_SLEEP_BIT];
		end else if (soft_busy) begin
			sleep <= PM_RESET[PM_SLEEP_BIT];
		end else if (seq == SEQ_OTP && otp_done) begin
			sleep <= 1'b1;
		end else if (wr_pm) begin
			sleep <= hwdata[PM_SLEEP_BIT];
		end
	end

	// reserved code keeps the last valid source running
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eff_src <= CLK_INT_OSC;
		end else if (soft_busy) begin
			eff_src <= CLK_INT_OSC;
		end else if (clk_sel != CLK_RESERVED) begin
			eff_src <= clk_sel;
		end
	end

	// registered outputs to the analog and datapath sides
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_enable        <= 1'b0;
			otp_read           <= 1'b0;
			buffer_write       <= 1'b0;
			buffer_flush       <= 1'b0;
			aux_master_enable  <= 1'b0;
			aux_passthrough    <= 1'b1;
			aux_reset          <= 1'b0;
			gyro_analog_reset  <= 1'b0;
			gyro_digital_reset <= 1'b0;
			device_soft_reset  <= 1'b0;
		end else begin
			pump_enable        <= ~soft_busy;
			otp_read           <= (next_seq == SEQ_OTP) & ~soft_busy;
			// no capture while flushing, asleep or with the clock stopped
			buffer_write       <= sample_valid & capture_en & ~buf_busy
				& ~sleep & (clk_sel != CLK_STOP);
			buffer_flush       <= buf_busy;
			aux_master_enable  <= aux_en;
			aux_passthrough    <= ~aux_en;
			aux_reset          <= aux_busy;
			gyro_analog_reset  <= gyro_busy;
			gyro_digital_reset <= gyro_busy;
			device_soft_reset  <= soft_busy;
		end
	end

	// power and clock outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_active       <= 1'b1;
			x_axis_standby    <= 1'b0;
			y_axis_standby    <= 1'b0;
			z_axis_standby    <= 1'b0;
			clock_source      <= CLK_INT_OSC;
			pll_enable        <= 1'b0;
			clock_stop        <= 1'b0;
			clock_state_reset <= 1'b0;
		end else begin
			core_active       <= ~sleep;
			x_axis_standby    <= standby[2] | sleep;
			y_axis_standby    <= standby[1] | sleep;
			z_axis_standby    <= standby[0] | sleep;
			clock_source      <= eff_src;
			// PLL sources need the gyro or reference; sleep drops them
			pll_enable        <= ~sleep & (eff_src != CLK_INT_OSC)
				& (eff_src != CLK_STOP);
			clock_stop        <= (clk_sel == CLK_STOP);
			clock_state_reset <= (clk_sel == CLK_STOP);
		end
	end
endmodule : pcrc_top
`default_nettype wire
